// [include/scr_pkg.sv]
// Constants and field layout for the sensor conditioner control register bank
package scr_pkg;
    // Register byte addresses
    localparam logic [7:0] SCR_ADDR_BIAS    = 8'h80;
    localparam logic [7:0] SCR_ADDR_ROW1    = 8'h81;
    localparam logic [7:0] SCR_ADDR_ROW2    = 8'h82;
    localparam logic [7:0] SCR_ADDR_FIRST_CURRENT_CONVERTER    = 8'h83;
    localparam logic [7:0] SCR_ADDR_DAC2    = 8'h84;
    localparam logic [7:0] SCR_ADDR_MANSEL  = 8'h85;
    localparam logic [7:0] SCR_ADDR_GATE    = 8'h86;
    localparam logic [7:0] SCR_ADDR_RESULT  = 8'h87;
    localparam logic [7:0] SCR_ADDR_RSV_LO  = 8'h88;
    localparam logic [7:0] SCR_ADDR_RSV_HI  = 8'h8F;
    // Bias config field positions
    localparam int SCR_BIT_REF_MODE = 2;
    localparam int SCR_BIT_FILT_OFF = 4;
    localparam int SCR_BIT_PERSIST  = 5;
    localparam int SCR_BIT_GEN1     = 6;
    localparam int SCR_BIT_GEN2     = 7;
    // Bit 3 of bias config always reads back as one
    localparam logic [7:0] SCR_BIAS_FIXED = 8'h08;
    // Manual access select field positions
    localparam int SCR_BIT_TAB1_SEL = 4;
    localparam int SCR_BIT_FIRST_CURRENT_CONVERTER_SEL = 5;
    localparam int SCR_BIT_TAB2_SEL = 6;
    localparam int SCR_BIT_DAC2_SEL = 7;
    // Write gate codes and latch position
    localparam int         SCR_BIT_LATCH  = 7;
    localparam logic [7:0] SCR_GATE_SET   = 8'h80;
    localparam logic [7:0] SCR_GATE_CLEAR = 8'h00;
    // Row index width and position of the result MSBs used as table row
    localparam int SCR_ROW_W   = 6;
    localparam int SCR_ROW_LSB = 2;
    // Equal conversions needed before the filtered result refreshes
    localparam logic [2:0] SCR_FILT_RUN = 3'h4;
    // Nonvolatile image byte lanes (bias, row1, row2, first_current_converter, dac2, mansel)
    localparam int SCR_NV_BYTES = 6;
    // Bit offset of each byte lane inside the nonvolatile image
    localparam int SCR_LANE_ROW1   = 8;
    localparam int SCR_LANE_ROW2   = 16;
    localparam int SCR_LANE_FIRST_CURRENT_CONVERTER   = 24;
    localparam int SCR_LANE_DAC2   = 32;
    localparam int SCR_LANE_MANSEL = 40;
    typedef enum {SCR_LOAD, SCR_RUN} scr_phase_t;
endpackage

// [rtl/scr_ctrl_regs.sv]
// Control and status register bank of the dual-channel sensor conditioner
`timescale 1ns/100ps
`default_nettype none
module scr_ctrl_regs (
    input  wire logic                              clock,
    input  wire logic                              reset,
    input  wire logic [8*scr_pkg::SCR_NV_BYTES-1:0] nv_image,
    input  wire logic [7:0]                        reg_addr,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    input  wire logic [7:0]                        reg_wdata,
    output logic      [7:0]                        reg_rdata,
    output logic                                   reg_rd_valid,
    output logic                                   reg_wr_ack,
    output logic                                   reg_wr_nak,
    input  wire logic                              adc_done,
    input  wire logic [7:0]                        adc_code,
    output logic                                   nv_wr,
    output logic      [7:0]                        nv_wr_addr,
    output logic      [7:0]                        nv_wr_data,
    output logic                                   ref_pin_mode,
    output logic                                   gen1_sink_select,
    output logic                                   gen2_sink_select,
    output logic                                   first_current_converter_manual_select,
    output logic                                   dac2_manual_select,
    output logic      [7:0]                        first_current_converter_code_bits,
    output logic      [7:0]                        dac2_code_bits,
    output logic      [5:0]                        first_table_row,
    output logic      [5:0]                        second_table_row,
    output logic                                   write_latch,
    output logic                                   ready
);
    import scr_pkg::*;

    typedef struct packed {
        scr_phase_t phase;
        logic       rdy;
        logic       ref_mode;
        logic       filt_off;
        logic       persist;
        logic       gen1;
        logic       gen2;
        logic [5:0] row1;
        logic [5:0] row2;
        logic [7:0] first_current_converter;
        logic [7:0] dac2;
        logic       tab1_sel;
        logic       first_current_converter_sel;
        logic       tab2_sel;
        logic       dac2_sel;
        logic       latch;
        logic [7:0] result;
        logic [5:0] last_msb;
        logic [2:0] run;
        logic [7:0] rdata;
        logic       rd_valid;
        logic       wr_ack;
        logic       wr_nak;
        logic       nv_wr;
        logic [7:0] nv_addr;
        logic [7:0] nv_data;
        logic [5:0] tab1;
        logic [5:0] tab2;
    } scr_state_t;

    scr_state_t s_r;
    scr_state_t s_nxt;

    // Helper views of the register bytes as read back
    logic [7:0] bias_byte;
    logic [7:0] mansel_byte;
    assign bias_byte = {s_r.gen2, s_r.gen1, s_r.persist, s_r.filt_off, 1'b0, s_r.ref_mode,
                        2'b00} | SCR_BIAS_FIXED;
    assign mansel_byte = {s_r.dac2_sel, s_r.tab2_sel, s_r.first_current_converter_sel, s_r.tab1_sel, 4'h0};

    // Next state: power-up load, register access, converter result filter
    always_comb begin
        logic       wr_ok;
        logic       nv_side;
        logic [7:0] rd_byte;
        s_nxt = s_r;
        wr_ok = 1'b0;
        nv_side = 1'b0;
        rd_byte = 8'h00;
        s_nxt.rd_valid = 1'b0;
        s_nxt.wr_ack = 1'b0;
        s_nxt.wr_nak = 1'b0;
        s_nxt.nv_wr = 1'b0;
        if (s_r.phase == SCR_LOAD) begin
            // Latch stays zero from reset; bytes 0..5 come from the cells
            s_nxt.ref_mode = nv_image[SCR_BIT_REF_MODE];
            s_nxt.filt_off = nv_image[SCR_BIT_FILT_OFF];
            s_nxt.persist  = nv_image[SCR_BIT_PERSIST];
            s_nxt.gen1     = nv_image[SCR_BIT_GEN1];
            s_nxt.gen2     = nv_image[SCR_BIT_GEN2];
            s_nxt.row1     = nv_image[SCR_LANE_ROW1 +: SCR_ROW_W];
            s_nxt.row2     = nv_image[SCR_LANE_ROW2 +: SCR_ROW_W];
            s_nxt.first_current_converter     = nv_image[SCR_LANE_FIRST_CURRENT_CONVERTER +: 8];
            s_nxt.dac2     = nv_image[SCR_LANE_DAC2 +: 8];
            s_nxt.tab1_sel = nv_image[SCR_LANE_MANSEL + SCR_BIT_TAB1_SEL];
            s_nxt.first_current_converter_sel = nv_image[SCR_LANE_MANSEL + SCR_BIT_FIRST_CURRENT_CONVERTER_SEL];
            s_nxt.tab2_sel = nv_image[SCR_LANE_MANSEL + SCR_BIT_TAB2_SEL];
            s_nxt.dac2_sel = nv_image[SCR_LANE_MANSEL + SCR_BIT_DAC2_SEL];
            s_nxt.phase = SCR_RUN;
            s_nxt.rdy   = 1'b1;
        end else begin
            // Read path; reserved and unknown addresses read as zero
            case (reg_addr)
                SCR_ADDR_BIAS:   rd_byte = bias_byte;
                SCR_ADDR_ROW1:   rd_byte = {2'b00, s_r.row1};
                SCR_ADDR_ROW2:   rd_byte = {2'b00, s_r.row2};
                SCR_ADDR_FIRST_CURRENT_CONVERTER:   rd_byte = s_r.first_current_converter;
                SCR_ADDR_DAC2:   rd_byte = s_r.dac2;
                SCR_ADDR_MANSEL: rd_byte = mansel_byte;
                SCR_ADDR_GATE:   rd_byte = {s_r.latch, 7'h00};
                SCR_ADDR_RESULT: rd_byte = s_r.result;
                default:         rd_byte = 8'h00;
            endcase
            if (reg_rd) begin
                s_nxt.rdata = rd_byte;
                s_nxt.rd_valid = 1'b1;
            end
            // Write path; the gate register itself is always writable
            if (reg_wr) begin
                if (reg_addr == SCR_ADDR_GATE) begin
                    wr_ok = 1'b1;
                    if (reg_wdata == SCR_GATE_SET) begin
                        s_nxt.latch = 1'b1;
                    end else if (reg_wdata == SCR_GATE_CLEAR) begin
                        s_nxt.latch = 1'b0;
                    end
                end else if (s_r.latch && reg_addr >= SCR_ADDR_BIAS
                             && reg_addr <= SCR_ADDR_RSV_HI) begin
                    wr_ok = 1'b1;
                    case (reg_addr)
                        SCR_ADDR_BIAS: begin
                            s_nxt.ref_mode = reg_wdata[SCR_BIT_REF_MODE];
                            s_nxt.filt_off = reg_wdata[SCR_BIT_FILT_OFF];
                            s_nxt.persist  = reg_wdata[SCR_BIT_PERSIST];
                            s_nxt.gen1     = reg_wdata[SCR_BIT_GEN1];
                            s_nxt.gen2     = reg_wdata[SCR_BIT_GEN2];
                            nv_side = 1'b1;
                        end
                        SCR_ADDR_ROW1: begin
                            s_nxt.row1 = reg_wdata[SCR_ROW_W-1:0];
                            nv_side = s_r.persist;
                        end
                        SCR_ADDR_ROW2: begin
                            s_nxt.row2 = reg_wdata[SCR_ROW_W-1:0];
                            nv_side = s_r.persist;
                        end
                        SCR_ADDR_FIRST_CURRENT_CONVERTER: begin
                            s_nxt.first_current_converter = reg_wdata;
                            nv_side = s_r.persist;
                        end
                        SCR_ADDR_DAC2: begin
                            s_nxt.dac2 = reg_wdata;
                            nv_side = s_r.persist;
                        end
                        SCR_ADDR_MANSEL: begin
                            s_nxt.tab1_sel = reg_wdata[SCR_BIT_TAB1_SEL];
                            s_nxt.first_current_converter_sel = reg_wdata[SCR_BIT_FIRST_CURRENT_CONVERTER_SEL];
                            s_nxt.tab2_sel = reg_wdata[SCR_BIT_TAB2_SEL];
                            s_nxt.dac2_sel = reg_wdata[SCR_BIT_DAC2_SEL];
                            nv_side = 1'b1;
                        end
                        default: begin
                            // Result and reserved bytes accept and drop data
                            nv_side = 1'b0;
                        end
                    endcase
                end
                // Without the latch, or off the map, the data byte is refused
                s_nxt.wr_ack = wr_ok;
                s_nxt.wr_nak = !wr_ok;
                s_nxt.nv_wr = nv_side;
                if (nv_side) begin
                    s_nxt.nv_addr = reg_addr;
                    s_nxt.nv_data = reg_wdata;
                end
            end
            // Conversion filter; the run counts equal upper-six-bit results
            if (adc_done) begin
                if (s_r.filt_off) begin
                    s_nxt.result = adc_code;
                    s_nxt.run = 3'h0;
                end else if (s_r.run != 3'h0
                             && adc_code[7:SCR_ROW_LSB] == s_r.last_msb) begin
                    if (s_r.run + 3'h1 == SCR_FILT_RUN) begin
                        s_nxt.result = adc_code;
                        s_nxt.run = 3'h0;
                    end else begin
                        s_nxt.run = s_r.run + 3'h1;
                    end
                end else begin
                    s_nxt.run = 3'h1;
                end
                s_nxt.last_msb = adc_code[7:SCR_ROW_LSB];
            end
        end
        // Table row picks follow the new register values on the same edge
        s_nxt.tab1 = s_nxt.tab1_sel ? s_nxt.row1 : s_nxt.result[7:SCR_ROW_LSB];
        s_nxt.tab2 = s_nxt.tab2_sel ? s_nxt.row2 : s_nxt.result[7:SCR_ROW_LSB];
    end

    // State register; reset stands for power-up and clears everything
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs taken straight from the state register
    assign reg_rdata          = s_r.rdata;
    assign reg_rd_valid       = s_r.rd_valid;
    assign reg_wr_ack         = s_r.wr_ack;
    assign reg_wr_nak         = s_r.wr_nak;
    assign nv_wr              = s_r.nv_wr;
    assign nv_wr_addr         = s_r.nv_addr;
    assign nv_wr_data         = s_r.nv_data;
    assign ref_pin_mode       = s_r.ref_mode;
    assign gen1_sink_select   = s_r.gen1;
    assign gen2_sink_select   = s_r.gen2;
    assign first_current_converter_manual_select = s_r.first_current_converter_sel;
    assign dac2_manual_select = s_r.dac2_sel;
    assign first_current_converter_code_bits     = s_r.first_current_converter;
    assign dac2_code_bits     = s_r.dac2;
    assign first_table_row    = s_r.tab1;
    assign second_table_row   = s_r.tab2;
    assign write_latch        = s_r.latch;
    assign ready              = s_r.rdy;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_gate_set: assert property (ready && reg_wr && reg_addr == SCR_ADDR_GATE
        && reg_wdata == SCR_GATE_SET |=> write_latch && reg_wr_ack)
        else $error("gate set code did not raise the latch");
    a_gate_clear: assert property (ready && reg_wr && reg_addr == SCR_ADDR_GATE
        && reg_wdata == SCR_GATE_CLEAR |=> !write_latch)
        else $error("gate clear code did not drop the latch");
    a_locked_nak: assert property (ready && reg_wr && !write_latch
        && reg_addr != SCR_ADDR_GATE |=> reg_wr_nak && !reg_wr_ack && !nv_wr)
        else $error("write without latch was not refused");
    a_result_ro: assert property (ready && reg_wr && reg_addr == SCR_ADDR_RESULT
        && !adc_done |=> $stable(s_r.result))
        else $error("write changed the conversion result");
    a_ref_mode: assert property (ready && reg_wr && write_latch
        && reg_addr == SCR_ADDR_BIAS |=>
        ref_pin_mode == $past(reg_wdata[SCR_BIT_REF_MODE])
        && gen1_sink_select == $past(reg_wdata[SCR_BIT_GEN1]))
        else $error("bias config write not applied");
    a_unfilt_upd: assert property (ready && adc_done && s_r.filt_off
        |=> s_r.result == $past(adc_code))
        else $error("unfiltered result not refreshed");
    a_filt_hold: assert property (ready && adc_done && !s_r.filt_off
        && s_r.run == 3'h0 && adc_code != s_r.result |=> s_r.result != $past(adc_code))
        else $error("filtered result refreshed after one conversion");
    a_persist_nv: assert property (ready && reg_wr && write_latch
        && reg_addr == SCR_ADDR_FIRST_CURRENT_CONVERTER |=> nv_wr == $past(s_r.persist))
        else $error("volatility choice not honoured");
    a_table_pick: assert property (ready ##1 ready |->
        first_table_row == (s_r.tab1_sel ? s_r.row1 : s_r.result[7:SCR_ROW_LSB]))
        else $error("first table row from wrong source");
    a_reserved_rd: assert property (ready && reg_rd && reg_addr >= SCR_ADDR_RSV_LO
        && reg_addr <= SCR_ADDR_RSV_HI |=> reg_rd_valid && reg_rdata == 8'h00)
        else $error("reserved byte read not zero");
    a_powerup_gate: assert property ($rose(ready) |-> !write_latch)
        else $error("latch set at power-up");

    c_unlock_write: cover property (write_latch && reg_wr && reg_addr == SCR_ADDR_DAC2);
    c_filt_update: cover property (adc_done && !s_r.filt_off && s_r.run == 3'h3
        && adc_code[7:SCR_ROW_LSB] == s_r.last_msb);
    c_nv_write: cover property (nv_wr);
endmodule // scr_ctrl_regs
`default_nettype wire

// [testbench/scr_bus_master.sv]
// Behavioural register bus master standing in for the serial host
`timescale 1ns/100ps
`default_nettype none
module scr_bus_master (
    input  wire logic       clock,
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid,
    input  wire logic       reg_wr_ack,
    input  wire logic       reg_wr_nak
);
    import scr_pkg::*;
    // Bus idle at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // One byte write; answer taken the cycle after the request edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        logic [7:0] v;
        v = d;
        if (a == SCR_ADDR_BIAS) v = (d | SCR_BIAS_FIXED) & 8'hFC;
        if (a == SCR_ADDR_MANSEL) v = d & 8'hF0;
        @(posedge clock);
        #1;
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'b1;
        @(posedge clock);
        #1;
        reg_wr    = 1'b0;
        // Released lines show the inverse so stale values are never trusted
        reg_addr  = ~a;
        reg_wdata = ~v;
        resp      = {reg_wr_ack, reg_wr_nak};
    endtask
    // One byte read; data without its valid pulse is returned as unknown
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clock);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d = (reg_rd_valid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule // scr_bus_master
`default_nettype wire

// [testbench/scr_ctrl_regs_test.sv]
// Self-checking testbench of the control and status register bank
`timescale 1ns/100ps
`default_nettype none
module scr_ctrl_regs_test;
    import scr_pkg::*;
    logic        clock, reset, adc_done, reg_wr, reg_rd, reg_rd_valid, reg_wr_ack, reg_wr_nak;
    logic        nv_wr, ref_pin_mode, gen1_sink_select, gen2_sink_select, write_latch, ready;
    logic        first_current_converter_manual_select, dac2_manual_select;
    logic [7:0]  adc_code, reg_addr, reg_wdata, reg_rdata, nv_wr_addr, nv_wr_data, rd_val;
    logic [7:0]  first_current_converter_code_bits, dac2_code_bits;
    logic [5:0]  first_table_row, second_table_row;
    logic [47:0] nv_image = 48'hF0A5_5A2A_154C;
    int          error_cnt, check_count, cycles;

    scr_ctrl_regs scr_ctrl_regs_inst (.clock, .reset, .nv_image, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_rd_valid, .reg_wr_ack, .reg_wr_nak, .adc_done, .adc_code,
        .nv_wr, .nv_wr_addr, .nv_wr_data, .ref_pin_mode, .gen1_sink_select, .gen2_sink_select,
        .first_current_converter_manual_select, .dac2_manual_select, .first_current_converter_code_bits, .dac2_code_bits,
        .first_table_row, .second_table_row, .write_latch, .ready);
    scr_bus_master scr_bus_master_inst (.clock, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_rd_valid, .reg_wr_ack, .reg_wr_nak);

    // Free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Verdict and end of run, reached from the main sequence or the watchdog
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Write and compare the answer: 2 is accepted, 1 is refused
    task automatic wx(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp);
        logic [1:0] r;
        scr_bus_master_inst.wr(a, d, r);
        check({6'h00, r}, {6'h00, exp});
    endtask
    task automatic rx(input logic [7:0] a, input logic [7:0] exp);
        scr_bus_master_inst.rd(a, rd_val);
        check(rd_val, exp);
    endtask
    // One conversion pulse; a quiet cycle always follows it
    task automatic conv(input logic [7:0] code);
        @(posedge clock);
        #1;
        adc_done = 1'b1;
        adc_code = code;
        @(posedge clock);
        #1;
        adc_done = 1'b0;
    endtask
    // Watchdog: the whole sequence needs well under 400 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // Nonvolatile cells: a store request rewrites its byte lane for the next power-up
    always @(posedge clock) begin
        if (nv_wr === 1'b1) begin
            nv_image[8*(nv_wr_addr - SCR_ADDR_BIAS) +: 8] <= nv_wr_data;
        end
    end

    initial begin
        reset    = 1'b1;
        adc_done = 1'b0;
        adc_code = 8'h00;
        repeat (4) @(posedge clock);
        #1;
        reset = 1'b0;
        for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clock);
        // Power-up image, derived outputs and manual table rows
        for (int i = 0; i < 6; i++) rx(8'h80 + 8'(i), nv_image[8*i+:8]);
        rx(SCR_ADDR_GATE, 8'h00);
        check({ref_pin_mode, gen1_sink_select, gen2_sink_select, write_latch,
               first_current_converter_manual_select, dac2_manual_select, 2'b00}, 8'hCC);
        check({2'b00, first_table_row}, 8'h15);
        check({2'b00, second_table_row}, 8'h2A);
        $display("power-up test done");
        // Writes refused until the latch is set
        wx(SCR_ADDR_FIRST_CURRENT_CONVERTER, 8'h11, 2'b01);
        check(first_current_converter_code_bits, 8'h5A);
        wx(SCR_ADDR_GATE, SCR_GATE_SET, 2'b10);
        check({7'h00, write_latch}, 8'h01);
        rx(SCR_ADDR_GATE, 8'h80);
        wx(8'h20, 8'h11, 2'b01);
        $display("latch test done");
        // Volatile and persistent writes
        wx(SCR_ADDR_FIRST_CURRENT_CONVERTER, 8'h11, 2'b10);
        check({7'h00, nv_wr}, 8'h00);
        check(first_current_converter_code_bits, 8'h11);
        wx(SCR_ADDR_BIAS, 8'h28, 2'b10);
        check({ref_pin_mode, gen1_sink_select, 6'h00}, 8'h00);
        wx(SCR_ADDR_DAC2, 8'h77, 2'b10);
        check({7'h00, nv_wr}, 8'h01);
        check(nv_wr_addr, SCR_ADDR_DAC2);
        check(nv_wr_data, 8'h77);
        check(dac2_code_bits, 8'h77);
        $display("persistence test done");
        // Read-only, reserved and odd gate writes change nothing
        wx(SCR_ADDR_RESULT, 8'h33, 2'b10);
        rx(SCR_ADDR_RESULT, 8'h00);
        wx(8'h8A, 8'h33, 2'b10);
        rx(8'h8A, 8'h00);
        wx(SCR_ADDR_GATE, 8'h55, 2'b10);
        rx(SCR_ADDR_GATE, 8'h80);
        $display("protection test done");
        // Filtered result: needs four conversions with equal upper six bits
        wx(SCR_ADDR_MANSEL, 8'h00, 2'b10);
        for (int i = 0; i < 3; i++) conv(8'h40 + 8'(i));
        rx(SCR_ADDR_RESULT, 8'h00);
        conv(8'h43);
        rx(SCR_ADDR_RESULT, 8'h43);
        check({2'b00, first_table_row}, 8'h10);
        // Unfiltered result follows every conversion
        wx(SCR_ADDR_BIAS, 8'h38, 2'b10);
        conv(8'h80);
        rx(SCR_ADDR_RESULT, 8'h80);
        conv(8'hC4);
        rx(SCR_ADDR_RESULT, 8'hC4);
        check({2'b00, second_table_row}, 8'h31);
        $display("conversion test done");
        // Clearing the latch blocks writes again
        wx(SCR_ADDR_GATE, SCR_GATE_CLEAR, 2'b10);
        check({7'h00, write_latch}, 8'h00);
        wx(SCR_ADDR_FIRST_CURRENT_CONVERTER, 8'h22, 2'b01);
        check(first_current_converter_code_bits, 8'h11);
        $display("latch clear test done");
        // Power cycle mid-run: latch drops, persisted bytes return, volatile ones do not
        @(posedge clock);
        #1;
        reset = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        reset = 1'b0;
        for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clock);
        check({7'h00, ready}, 8'h01);
        rx(SCR_ADDR_GATE, 8'h00);
        rx(SCR_ADDR_BIAS, 8'h38);
        rx(SCR_ADDR_FIRST_CURRENT_CONVERTER, 8'h5A);
        rx(SCR_ADDR_DAC2, 8'h77);
        rx(SCR_ADDR_MANSEL, 8'h00);
        $display("power cycle test done");
        print_verdict();
    end
endmodule // scr_ctrl_regs_test
`default_nettype wire
